// ### hdl/burst_sram_pkg.sv
// constants shared by the burst memory port and its storage array
package burst_sram_pkg;
  localparam int unsigned WORDS = 131072;
  localparam int unsigned ADDR_W = 17;
  localparam int unsigned LANES = 4;
  localparam int unsigned LANE_W = 9;
  localparam int unsigned BURST_W = 2;
  localparam int unsigned DESELECT_HOLD = 2;
  localparam logic [1:0] HOLD_RESET = 2'h0;
endpackage

// ### hdl/burst_sram_array.sv
// storage array with per-lane write and registered read data
`timescale 1ns/1ps
module burst_sram_array #(
  parameter int unsigned DEPTH = burst_sram_pkg::WORDS,
  parameter int unsigned AW = burst_sram_pkg::ADDR_W,
  parameter int unsigned LANES = burst_sram_pkg::LANES,
  parameter int unsigned LANE_W = burst_sram_pkg::LANE_W
) (
  input wire logic i_core_clk,
  input wire logic [AW-1:0] i_addr,
  input wire logic [LANES-1:0] i_lane_we,
  input wire logic [LANES*LANE_W-1:0] i_wdata,
  output logic [LANES*LANE_W-1:0] o_rdata
);
  logic [LANES*LANE_W-1:0] mem [DEPTH];

  initial begin
    if (DEPTH > (1 << AW)) begin
      $error("depth exceeds address range");
    end
  end

  // per-lane write ports
  genvar g;
  for (g = 0; g < LANES; g++) begin : g_lane
    always_ff @(posedge i_core_clk) begin
      if (i_lane_we[g]) begin
        mem[i_addr][g*LANE_W +: LANE_W] <= i_wdata[g*LANE_W +: LANE_W];
      end
    end
  end

  // registered read
  always_ff @(posedge i_core_clk) begin
    o_rdata <= mem[i_addr];
  end
endmodule

// ### hdl/burst_sram_port.sv
// pipelined burst static memory port: control, burst, pipeline, drivers
`timescale 1ns/1ps
module burst_sram_port #(
  parameter int unsigned AW = burst_sram_pkg::ADDR_W,
  parameter int unsigned LANES = burst_sram_pkg::LANES,
  parameter int unsigned LANE_W = burst_sram_pkg::LANE_W
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic [AW-1:0] i_addr,
  input wire logic i_proc_addr_strobe_n,
  input wire logic i_ctrl_addr_strobe_n,
  input wire logic i_burst_step_n,
  input wire logic i_all_lanes_write_n,
  input wire logic i_lane_write_gate_n,
  input wire logic [LANES-1:0] i_lane_writes_n,
  input wire logic i_master_select_n,
  input wire logic i_aux_select_high,
  input wire logic i_aux_select_low_n,
  input wire logic i_order_select,
  input wire logic i_output_enable_n,
  input wire logic [LANES*LANE_W-1:0] i_data,
  output logic [LANES*LANE_W-1:0] o_data,
  output logic o_data_oe_n,
  output logic o_rd_valid,
  input wire logic i_rd_ready
);
  localparam int unsigned DW = LANES * LANE_W;
  localparam int unsigned BW = burst_sram_pkg::BURST_W;

  initial begin
    if (AW != burst_sram_pkg::ADDR_W || LANES != burst_sram_pkg::LANES) begin
      $error("port geometry differs from the array");
    end
    if (AW <= burst_sram_pkg::BURST_W) begin
      $error("address too narrow for a burst group");
    end
  end

  // bus state
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b100
  } bus_state_t;

  // two-flop input synchronisers for pins from the shared bus
  // output enable stays off this path: it acts without waiting for a clock
  localparam int unsigned SW = AW + 9 + LANES + DW;
  logic [SW-1:0] pin_meta;
  logic [SW-1:0] pin_sync;
  always_ff @(posedge i_core_clk) begin
    pin_meta <= {i_addr, i_proc_addr_strobe_n, i_ctrl_addr_strobe_n,
                 i_burst_step_n, i_all_lanes_write_n, i_lane_write_gate_n,
                 i_lane_writes_n, i_master_select_n, i_aux_select_high,
                 i_aux_select_low_n, i_order_select, i_data};
    pin_sync <= pin_meta;
  end

  logic [AW-1:0] s_addr;
  logic s_padsn, s_cadsn, s_stepn, s_gwn, s_gaten, s_cs0n, s_cs1, s_cs2n;
  logic s_order;
  logic [LANES-1:0] s_bwn;
  logic [DW-1:0] s_data;
  assign {s_addr, s_padsn, s_cadsn, s_stepn, s_gwn, s_gaten, s_bwn, s_cs0n,
          s_cs1, s_cs2n, s_order, s_data} = pin_sync;

  // chip select and strobe qualification
  logic sel_all;
  logic proc_go;
  logic ctrl_go;
  logic lane_wr_any;
  logic [LANES-1:0] lane_we;
  assign sel_all = !s_cs0n && s_cs1 && !s_cs2n;
  assign proc_go = !s_padsn && !s_cs0n;
  assign ctrl_go = !s_cadsn && s_padsn;

  // per-lane write decode, blanked on the processor strobe edge
  genvar g;
  for (g = 0; g < LANES; g++) begin : g_we
    assign lane_we[g] = !proc_go &&
                        (!s_gwn || (!s_gaten && !s_bwn[g]));
  end
  assign lane_wr_any = |lane_we;

  // address, burst and state registers
  bus_state_t state;
  bus_state_t next_state;
  logic [AW-1:0] base_addr;
  logic [AW-1:0] next_base_addr;
  logic [BW-1:0] burst_count;
  logic [BW-1:0] next_burst_count;
  logic order_lin;
  logic next_order_lin;
  logic [1:0] hold_count;
  logic [1:0] next_hold_count;

  always_comb begin
    next_state = state;
    next_base_addr = base_addr;
    next_burst_count = burst_count;
    next_order_lin = order_lin;
    next_hold_count = hold_count;
    if (proc_go || ctrl_go) begin
      if (sel_all) begin
        next_base_addr = s_addr;
        next_burst_count = '0;
        next_order_lin = !s_order;
        next_state = (ctrl_go && lane_wr_any) ? ST_WRITE : ST_READ;
      end else begin
        next_state = ST_IDLE;
      end
    end else if (state != ST_IDLE) begin
      next_state = lane_wr_any ? ST_WRITE : ST_READ;
      if (!s_stepn && s_padsn && s_cadsn) begin
        next_burst_count = burst_count + 1'b1;
      end
    end
    // drivers linger after a read burst ends
    case (state)
      ST_READ: next_hold_count = 2'(burst_sram_pkg::DESELECT_HOLD);
      ST_WRITE: next_hold_count = burst_sram_pkg::HOLD_RESET;
      ST_IDLE: begin
        if (hold_count != 2'h0) begin
          next_hold_count = hold_count - 2'h1;
        end
      end
      default: next_hold_count = burst_sram_pkg::HOLD_RESET;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state <= ST_IDLE;
      base_addr <= '0;
      burst_count <= '0;
      order_lin <= 1'b0;
      hold_count <= burst_sram_pkg::HOLD_RESET;
    end else begin
      state <= next_state;
      base_addr <= next_base_addr;
      burst_count <= next_burst_count;
      order_lin <= next_order_lin;
      hold_count <= next_hold_count;
    end
  end

  // address for the coming edge, so a step lands on this very fetch
  logic [BW-1:0] low_bits;
  logic [AW-1:0] cur_addr;
  always_comb begin
    if (next_order_lin) begin
      low_bits = next_base_addr[BW-1:0] + next_burst_count;
    end else begin
      low_bits = next_base_addr[BW-1:0] ^ next_burst_count;
    end
    cur_addr = {next_base_addr[AW-1:BW], low_bits};
  end

  // input address and data registers feeding the array
  logic [AW-1:0] arr_addr;
  logic [LANES-1:0] arr_we;
  logic [DW-1:0] arr_wdata;
  logic [LANES-1:0] next_arr_we;
  logic [DW-1:0] next_arr_wdata;
  logic wr_seen;
  logic next_wr_seen;
  logic rd_issue;
  logic next_rd_issue;
  logic [DW-1:0] arr_rdata;
  logic ctrl_wr_first;
  assign ctrl_wr_first = ctrl_go && sel_all && lane_wr_any;
  // a load or a burst step names a new word to fetch
  logic addr_event;
  assign addr_event = proc_go || ctrl_go || (!s_stepn && s_padsn && s_cadsn);

  // array strobes: a write, or one read per address event
  always_comb begin
    next_arr_we = '0;
    next_arr_wdata = arr_wdata;
    next_wr_seen = lane_wr_any && (state != ST_IDLE || ctrl_wr_first);
    next_rd_issue = 1'b0;
    if (next_wr_seen) begin
      next_arr_we = lane_we;
      next_arr_wdata = s_data;
    end else if (next_state == ST_READ && addr_event) begin
      next_rd_issue = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      arr_addr <= '0;
      arr_we <= '0;
      arr_wdata <= '0;
      wr_seen <= 1'b0;
      rd_issue <= 1'b0;
    end else begin
      arr_addr <= (proc_go || ctrl_go) ? s_addr : cur_addr;
      arr_we <= next_arr_we;
      arr_wdata <= next_arr_wdata;
      wr_seen <= next_wr_seen;
      rd_issue <= next_rd_issue;
    end
  end

  burst_sram_array #(
    .DEPTH(burst_sram_pkg::WORDS),
    .AW(AW),
    .LANES(LANES),
    .LANE_W(LANE_W)
  ) u_array (
    .i_core_clk(i_core_clk),
    .i_addr(arr_addr),
    .i_lane_we(arr_we),
    .i_wdata(arr_wdata),
    .o_rdata(arr_rdata)
  );

  // read data returns one edge after the address register
  logic rd_ret;
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      rd_ret <= 1'b0;
    end else begin
      rd_ret <= rd_issue;
    end
  end

  // two-entry output buffer: a stalled receiver keeps two words, later ones are dropped
  logic [DW-1:0] buf_data [2];
  logic [DW-1:0] next_buf0, next_buf1;
  logic [1:0] buf_cnt;
  logic [1:0] next_buf_cnt;
  logic buf_pop;
  logic buf_push;
  assign buf_pop = (buf_cnt != 2'h0) && i_rd_ready;
  assign buf_push = rd_ret && (buf_cnt != 2'h2 || buf_pop);

  always_comb begin
    next_buf0 = buf_data[0];
    next_buf1 = buf_data[1];
    next_buf_cnt = buf_cnt;
    if (buf_pop) begin
      next_buf0 = buf_data[1];
      next_buf_cnt = next_buf_cnt - 2'h1;
    end
    if (buf_push) begin
      if (next_buf_cnt == 2'h0) begin
        next_buf0 = arr_rdata;
      end else begin
        next_buf1 = arr_rdata;
      end
      next_buf_cnt = next_buf_cnt + 2'h1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      buf_data[0] <= '0;
      buf_data[1] <= '0;
      buf_cnt <= 2'h0;
    end else begin
      buf_data[0] <= next_buf0;
      buf_data[1] <= next_buf1;
      buf_cnt <= next_buf_cnt;
    end
  end

  assign o_data = buf_data[0];
  assign o_rd_valid = (buf_cnt != 2'h0);

  // drivers: read cycle or deselect hold, output enable, write override
  logic read_mode;
  assign read_mode = (state == ST_READ) || (hold_count != 2'h0);
  assign o_data_oe_n = !(read_mode && !i_output_enable_n
                         && !wr_seen && !(|arr_we));
endmodule

// ### tb/burst_sram_port_assertions.sv
// pin-level checker for the burst memory port
`timescale 1ns/1ps
module burst_sram_port_assertions #(
  parameter int unsigned LANES = 4,
  parameter int unsigned LANE_W = 9
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_proc_addr_strobe_n,
  input wire logic i_ctrl_addr_strobe_n,
  input wire logic i_burst_step_n,
  input wire logic i_all_lanes_write_n,
  input wire logic i_master_select_n,
  input wire logic i_aux_select_high,
  input wire logic i_aux_select_low_n,
  input wire logic i_output_enable_n,
  input wire logic [LANES*LANE_W-1:0] o_data,
  input wire logic o_data_oe_n,
  input wire logic o_rd_valid,
  input wire logic i_rd_ready
);
  logic sel;
  logic rd_any;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  // master and high aux selects active; any request that may bring a word
  assign sel = !i_master_select_n && i_aux_select_high;
  assign rd_any = sel && !i_aux_select_low_n
    && !(i_proc_addr_strobe_n && i_ctrl_addr_strobe_n) || !i_burst_step_n;
  sequence s_rd_req;
    !i_proc_addr_strobe_n && sel && !i_aux_select_low_n;
  endsequence
  sequence s_desel;
    !i_ctrl_addr_strobe_n && i_master_select_n
      ##1 (i_proc_addr_strobe_n && i_ctrl_addr_strobe_n)[*8];
  endsequence
  a_reset_quiet: assert property (disable iff (1'h0)
    i_reset |=> !o_rd_valid && o_data_oe_n) else $error("active after reset");
  a_oe_gates_pins: assert property (
    i_output_enable_n |-> o_data_oe_n) else $error("driving with oe off");
  a_read_latency: assert property (
    s_rd_req |-> ##5 o_rd_valid) else $error("read word late");
  a_no_spurious: assert property (
    $rose(o_rd_valid) |-> $past(rd_any, 5)) else $error("word from nowhere");
  a_valid_stands: assert property (
    o_rd_valid && !i_rd_ready |=> o_rd_valid) else $error("word lost");
  a_data_stands: assert property (
    o_rd_valid && !i_rd_ready |=> $stable(o_data)) else $error("data moved");
  a_write_off: assert property (
    (i_proc_addr_strobe_n && !i_all_lanes_write_n)[*4] |-> o_data_oe_n)
    else $error("driving during write");
  a_desel_release: assert property (
    s_desel |-> o_data_oe_n) else $error("pins held after deselect");
endmodule
bind burst_sram_port burst_sram_port_assertions #(
  .LANES(LANES), .LANE_W(LANE_W)) u_chk (
  .i_core_clk(i_core_clk), .i_reset(i_reset),
  .i_proc_addr_strobe_n(i_proc_addr_strobe_n),
  .i_ctrl_addr_strobe_n(i_ctrl_addr_strobe_n),
  .i_burst_step_n(i_burst_step_n),
  .i_all_lanes_write_n(i_all_lanes_write_n),
  .i_master_select_n(i_master_select_n),
  .i_aux_select_high(i_aux_select_high),
  .i_aux_select_low_n(i_aux_select_low_n),
  .i_output_enable_n(i_output_enable_n), .o_data(o_data),
  .o_data_oe_n(o_data_oe_n), .o_rd_valid(o_rd_valid),
  .i_rd_ready(i_rd_ready));

// ### tb/burst_read_sink.sv
// receiving side that pops read words and can stall
`timescale 1ns/1ps
module burst_read_sink #(parameter int unsigned W = 36) (
  input wire logic i_core_clk,
  input wire logic i_stall,
  input wire logic i_valid,
  input wire logic [W-1:0] i_data,
  output logic o_ready
);
  logic [W-1:0] words[$];
  assign o_ready = !i_stall;
  // keep every word taken
  always @(posedge i_core_clk) begin
    if (i_valid && o_ready) begin
      words.push_back(i_data);
    end
  end
endmodule

// ### tb/tb_burst_sram_port.sv
// self-checking bench for the burst memory port
`timescale 1ns/1ps
module tb_burst_sram_port;
  logic clk = 1'h0, rst = 1'h1, ps_n = 1'h1, cs_n = 1'h1, st_n = 1'h1;
  logic gw_n = 1'h1, gt_n = 1'h1, m_n = 1'h0, ah = 1'h1, al_n = 1'h0;
  logic ord = 1'h1, oe_n = 1'h1, doe_n, vld, rdy, stall = 1'h0;
  logic [3:0] bw_n = 4'hf;
  logic [16:0] addr = 17'h0;
  logic [35:0] din = 36'h0, dout;
  logic [35:0] mem[int];
  int err_count = 0, n_compared = 0, cyc = 0;
  always #5 clk = ~clk;
  burst_sram_port u_dut (.i_core_clk(clk), .i_reset(rst), .i_addr(addr),
    .i_proc_addr_strobe_n(ps_n), .i_ctrl_addr_strobe_n(cs_n),
    .i_burst_step_n(st_n), .i_all_lanes_write_n(gw_n),
    .i_lane_write_gate_n(gt_n), .i_lane_writes_n(bw_n),
    .i_master_select_n(m_n), .i_aux_select_high(ah),
    .i_aux_select_low_n(al_n), .i_order_select(ord),
    .i_output_enable_n(oe_n), .i_data(din), .o_data(dout),
    .o_data_oe_n(doe_n), .o_rd_valid(vld), .i_rd_ready(rdy));
  burst_read_sink u_sink (.i_core_clk(clk), .i_stall(stall),
    .i_valid(vld), .i_data(dout), .o_ready(rdy));
  // burst address k of a group, interleaved or linear
  function automatic logic [16:0] nxt(logic [16:0] a, int k);
    nxt = {a[16:2], ord ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k)};
  endfunction
  task automatic chk(string what, logic [35:0] got, logic [35:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // strobes and writes released, burst step set by s; data lines keep changing
  task automatic idle(logic s);
    ps_n <= 1'h1;
    cs_n <= 1'h1;
    st_n <= s;
    gw_n <= 1'h1;
    gt_n <= 1'h1;
    bw_n <= 4'hf;
    din <= ~din;
  endtask
  task automatic wr(logic [16:0] a, logic g, t, logic [3:0] l, logic [35:0] d);
    logic [35:0] v;
    int n;
    logic wrote;
    n = u_sink.words.size();
    wrote = !g || (!t && l != 4'hf);
    for (int k = 0; k < 4; k++) begin
      v = d + 36'(k);
      @(posedge clk);
      cs_n <= (k != 0);
      st_n <= (k == 0);
      addr <= a;
      gw_n <= g;
      gt_n <= t;
      bw_n <= l;
      din <= v;
      for (int i = 0; i < 4; i++) begin
        if (!g || (!t && !l[i])) mem[nxt(a, k)][9*i+:9] = v[9*i+:9];
      end
    end
    @(posedge clk);
    idle(1'h1);
    repeat (8) @(posedge clk);
    chk("reads", 36'(u_sink.words.size() - n), wrote ? 36'h0 : 36'h4);
    $display("write %h done", a);
  endtask
  task automatic rd(logic [16:0] a);
    int n;
    n = u_sink.words.size();
    @(posedge clk);
    ps_n <= 1'h0;
    addr <= a;
    gt_n <= 1'h0;
    bw_n <= 4'h0;
    repeat (3) begin
      @(posedge clk);
      idle(1'h0);
    end
    @(posedge clk);
    idle(1'h1);
    repeat (8) @(posedge clk);
    chk("count", 36'(u_sink.words.size() - n), 36'h4);
    chk("drive", 36'(doe_n), 36'h0);
    for (int k = 0; k < 4; k++) begin
      chk("word", u_sink.words[n+k], mem[nxt(a, k)]);
    end
    $display("read %h done", a);
  endtask
  task automatic desel();
    @(posedge clk);
    cs_n <= 1'h0;
    m_n <= 1'h1;
    @(posedge clk);
    cs_n <= 1'h1;
    m_n <= 1'h0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("linger", 36'(doe_n), 36'h0);
    @(negedge clk);
    chk("release", 36'(doe_n), 36'h1);
    repeat (5) @(posedge clk);
    $display("deselect done");
  endtask
  task automatic nr(logic m, h, l);
    int n;
    n = u_sink.words.size();
    @(posedge clk);
    {m_n, ah, al_n, ps_n} <= {m, h, l, 1'h0};
    @(posedge clk);
    {m_n, ah, al_n, ps_n} <= 4'h5;
    repeat (8) @(posedge clk);
    chk("blocked", 36'(u_sink.words.size() - n), 36'h0);
    $display("blocked read done");
  endtask
  task automatic stl();
    int n;
    n = u_sink.words.size();
    stall <= 1'h1;
    @(posedge clk);
    ps_n <= 1'h0;
    addr <= 17'h10;
    @(posedge clk);
    addr <= 17'h12;
    @(posedge clk);
    ps_n <= 1'h1;
    repeat (8) @(posedge clk);
    chk("held", dout, mem[17'h10]);
    stall <= 1'h0;
    repeat (4) @(posedge clk);
    chk("second", u_sink.words[n+1], mem[17'h12]);
    $display("stall done");
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      wrap_up();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    wr(17'h10, 1'h0, 1'h1, 4'hf, 36'h123456789);
    oe_n <= 1'h0;
    rd(17'h11);
    ord <= 1'h0;
    rd(17'h12);
    ord <= 1'h1;
    desel();
    oe_n <= 1'h1;
    wr(17'h10, 1'h1, 1'h0, 4'ha, 36'hfedcba987);
    wr(17'h10, 1'h1, 1'h1, 4'h0, 36'h0);
    oe_n <= 1'h0;
    rd(17'h13);
    nr(1'h1, 1'h1, 1'h0);
    nr(1'h0, 1'h0, 1'h0);
    nr(1'h0, 1'h1, 1'h1);
    stl();
    wrap_up();
  end
endmodule
